// file: design/tlp_defines.svh
// register map, field positions and timing constants of the line print sequencer
`ifndef TLP_DEFINES_SVH
`define TLP_DEFINES_SVH
`define TLP_A_CTRL      8'h00
`define TLP_A_STRB1     8'h04
`define TLP_A_STRB2     8'h08
`define TLP_A_PERIOD    8'h0C
`define TLP_A_LINES     8'h10
`define TLP_A_DATA      8'h14
`define TLP_A_STATUS    8'h18
`define TLP_CTRL_START  0
`define TLP_CTRL_ONEDIV 1
`define TLP_CTRL_DYN    2
`define TLP_CTRL_MASKA  13:8
`define TLP_CTRL_MASKB  21:16
`define TLP_ST_BUSY     0
`define TLP_ST_PAPER    1
`define TLP_ST_ERR      2
`define TLP_ST_FIFO     7:4
`define TLP_ST_LINES    31:16
`define TLP_FIX_MASK_A  6'h07
`define TLP_FIX_MASK_B  6'h38
`define TLP_MASK_ALL    6'h3F
`define TLP_WORDS       12
`define TLP_LAST_WORD   4'hB
`define TLP_LAST_BIT    5'h1F
`define TLP_XFER_RISE   3'h3
`define TLP_XFER_END    3'h7
`define TLP_PHASE_TAB   16'h956A
`define TLP_PH_OFF      4'h0
`define TLP_FIFO_DEPTH  8
`define TLP_CLK_NS      20
`define TLP_LATCH_NS    100
`define TLP_LATCH_CYC   ((`TLP_LATCH_NS + `TLP_CLK_NS - 1) / `TLP_CLK_NS)
`define TLP_SETUP_NS    300
`define TLP_SETUP_CYC   ((`TLP_SETUP_NS + `TLP_CLK_NS - 1) / `TLP_CLK_NS)
`define TLP_PAUSE_NS    500000
`define TLP_PAUSE_CYC   ((`TLP_PAUSE_NS + `TLP_CLK_NS - 1) / `TLP_CLK_NS)
`endif

// file: design/tlp_pkg.sv
// types shared by the line print sequencer
`default_nettype none
`include "tlp_defines.svh"
package tlp_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_LATCH = 6'h02,
    ST_STEP  = 6'h04,
    ST_STRA  = 6'h08,
    ST_STRB  = 6'h10,
    ST_PAUSE = 6'h20
  } tlp_state_e;
  typedef struct packed {
    logic       head_latch;
    logic       xfer_clk;
    logic       serial_dot_input;
    logic [5:0] head_strobe_group;
    logic [3:0] motor_phase;
  } tlp_head_s;
  typedef struct packed {
    logic        one_div;
    logic        dynamic;
    logic [5:0]  mask_a;
    logic [5:0]  mask_b;
    logic [15:0] t1;
    logic [15:0] t2;
    logic [19:0] period;
    logic [15:0] lines;
  } tlp_ctrl_s;
  typedef struct packed {
    tlp_state_e                       st;
    logic                             ps1;
    logic                             ps2;
    logic                             pready;
    logic [31:0]                      prdata;
    logic                             pslverr;
    tlp_ctrl_s                        ctrl;
    logic                             err;
    tlp_head_s                        head;
    logic [1:0]                       pidx;
    logic                             step2;
    logic [15:0]                      lines_left;
    logic [15:0]                      tmr;
    logic [19:0]                      step_tmr;
    logic                             sh_busy;
    logic                             sh_src2;
    logic                             sh_have;
    logic [31:0]                      sh_word;
    logic [4:0]                       sh_bit;
    logic [3:0]                       sh_idx;
    logic [2:0]                       sh_div;
    logic [`TLP_WORDS-1:0][31:0]      lbuf;
  } tlp_top_s;
endpackage
`default_nettype wire

// file: design/tlp_seq.sv
// line print sequencer: fifo and top level controller with apb registers
//
// Overview of operation
// - never more than 64 dots heated at once over active groups; the sequencer counts no dots and strobes whole groups by mask.
// - idle leaves motor unpowered and all strobe groups low.
// - a run starts by re-driving the last motor phase pattern.
// - start step latches the first step data before any motor step.
// - two-division step: one motor step, then groups one to three strobed.
// - after the first group, groups four to six are strobed.
// - next step data is shifted while current strobes are active.
// - second step of a dot line resends identical dot data.
// - latch only after all strobes of the step have finished.
// - second step of a line uses a shorter strobe time.
// - next motor step waits until transfer and printing complete.
// - one-division mode pauses at least 0.5 ms after activation.
// - fixed division strobes the same group sets in the same order.
// - dynamic division regroups blocks per line within the dot limit; here the groups are the mask_a and mask_b control fields, with no dot count.
// - dot data shifts into the head with the transfer clock.
// - no paper inhibits strobes and motor stepping.
`timescale 1ns/100ps
`default_nettype none
`include "tlp_defines.svh"

module tlp_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  output logic [$clog2(D):0]          count
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } tlp_fifo_s;
  tlp_fifo_s r;
  tlp_fifo_s n;
  logic      push;
  logic      pop;

  // flags and read port from registered state
  assign in_ready  = (r.cnt != (AW+1)'(D));
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rp];
  assign count     = r.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp        = r.wp + AW'(1);
    end
    if (pop) begin
      n.rp = r.rp + AW'(1);
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

module tlp_seq #(
  parameter int PAUSE_CYC = `TLP_PAUSE_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              paper_sense_out,
  output tlp_pkg::tlp_head_s     head_pins
);
  localparam logic [15:0] PHASE_TAB = `TLP_PHASE_TAB;
  tlp_pkg::tlp_top_s r;
  tlp_pkg::tlp_top_s n;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [31:0]       fifo_data;
  logic [3:0]        fifo_count;
  logic              acc;
  logic              start;
  logic              mapped;
  logic              step_done;
  logic              last;
  logic              shift_next;
  logic [15:0]       tstr;
  logic [5:0]        ma;
  logic [5:0]        mb;
  logic [31:0]       rd;

  // outputs straight from the state register
  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign head_pins = r.head;

  // fifo pops only while the shifter waits for a fresh line word
  assign fifo_out_ready = r.sh_busy & ~r.sh_have & ~r.sh_src2;
  assign acc            = psel & penable;
  assign fifo_in_valid  = acc & r.pready & pwrite & ~r.pslverr & (paddr == `TLP_A_DATA);

  tlp_fifo #(.W(32), .D(`TLP_FIFO_DEPTH)) u_fifo (
    .clk       (pclk),
    .rstn      (presetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_data),
    .count     (fifo_count)
  );

  // next state of bus slave, shifter and sequencer
  always_comb begin
    n          = r;
    start      = 1'b0;
    step_done  = 1'b0;
    shift_next = 1'b0;
    n.ps1      = paper_sense_out;
    n.ps2      = r.ps1;                         // low = no paper
    mapped = (paddr == `TLP_A_CTRL) || (paddr == `TLP_A_STRB1) || (paddr == `TLP_A_STRB2) ||
             (paddr == `TLP_A_PERIOD) || (paddr == `TLP_A_LINES) ||
             (paddr == `TLP_A_DATA) || (paddr == `TLP_A_STATUS);
    rd = 32'h0000_0000;
    case (paddr)
      `TLP_A_CTRL: begin
        rd[`TLP_CTRL_ONEDIV] = r.ctrl.one_div;
        rd[`TLP_CTRL_DYN]    = r.ctrl.dynamic;
        rd[`TLP_CTRL_MASKA]  = r.ctrl.mask_a;
        rd[`TLP_CTRL_MASKB]  = r.ctrl.mask_b;
      end
      `TLP_A_STRB1:  rd[15:0] = r.ctrl.t1;
      `TLP_A_STRB2:  rd[15:0] = r.ctrl.t2;
      `TLP_A_PERIOD: rd[19:0] = r.ctrl.period;
      `TLP_A_LINES:  rd[15:0] = r.ctrl.lines;
      `TLP_A_STATUS: begin
        rd[`TLP_ST_BUSY]  = (r.st != tlp_pkg::ST_IDLE);
        rd[`TLP_ST_PAPER] = r.ps2;
        rd[`TLP_ST_ERR]   = r.err;
        rd[`TLP_ST_FIFO]  = fifo_count;
        rd[`TLP_ST_LINES] = r.lines_left;
      end
      default: rd = 32'h0000_0000;
    endcase
    // apb: one wait state, data writes wait for fifo room
    if (acc && !r.pready) begin
      if (!(pwrite && paddr == `TLP_A_DATA && mapped) || fifo_in_ready) begin
        n.pready  = 1'b1;
        n.prdata  = pwrite ? 32'h0000_0000 : rd;
        n.pslverr = ~mapped;
      end
    end
    if (acc && r.pready) begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      if (pwrite && !r.pslverr) begin
        case (paddr)
          `TLP_A_CTRL: begin
            n.ctrl.one_div = pwdata[`TLP_CTRL_ONEDIV];
            n.ctrl.dynamic = pwdata[`TLP_CTRL_DYN];
            n.ctrl.mask_a  = pwdata[`TLP_CTRL_MASKA];
            n.ctrl.mask_b  = pwdata[`TLP_CTRL_MASKB];
            start          = pwdata[`TLP_CTRL_START];
          end
          `TLP_A_STRB1:  n.ctrl.t1     = pwdata[15:0];
          `TLP_A_STRB2:  n.ctrl.t2     = pwdata[15:0];
          `TLP_A_PERIOD: n.ctrl.period = pwdata[19:0];
          `TLP_A_LINES:  n.ctrl.lines  = pwdata[15:0];
          default: n.ctrl = r.ctrl;
        endcase
      end
    end
    // motor step period timer
    if (r.step_tmr != 20'h00000) begin
      n.step_tmr = r.step_tmr - 20'h00001;
    end
    // serial shifter: data set while clock low, head samples on the rise
    if (r.sh_busy) begin
      if (!r.sh_have) begin
        if (r.sh_src2) begin
          n.sh_word                   = r.lbuf[r.sh_idx];
          n.head.serial_dot_input     = r.lbuf[r.sh_idx][31];
          n.sh_have                   = 1'b1;
        end else if (fifo_out_valid) begin
          n.sh_word                   = fifo_data;
          n.lbuf[r.sh_idx]            = fifo_data;
          n.head.serial_dot_input     = fifo_data[31];
          n.sh_have                   = 1'b1;
        end
      end else begin
        n.sh_div = r.sh_div + 3'h1;
        if (r.sh_div == `TLP_XFER_RISE) begin
          n.head.xfer_clk = 1'b1;
        end
        if (r.sh_div == `TLP_XFER_END) begin
          n.head.xfer_clk         = 1'b0;
          n.sh_word               = {r.sh_word[30:0], 1'b0};
          n.head.serial_dot_input = r.sh_word[30];
          n.sh_bit                = r.sh_bit + 5'h01;
          if (r.sh_bit == `TLP_LAST_BIT) begin
            n.sh_have = 1'b0;
            n.sh_idx  = r.sh_idx + 4'h1;
            if (r.sh_idx == `TLP_LAST_WORD) begin
              n.sh_busy = 1'b0;
            end
          end
        end
      end
    end
    // strobe time and group selection
    if (r.step2) begin
      tstr = (r.ctrl.t2 < r.ctrl.t1) ? r.ctrl.t2 :
             ((r.ctrl.t1 != 16'h0000) ? r.ctrl.t1 - 16'h0001 : 16'h0000);
    end else begin
      tstr = r.ctrl.t1;
    end
    ma   = r.ctrl.dynamic ? r.ctrl.mask_a : `TLP_FIX_MASK_A;
    mb   = r.ctrl.dynamic ? r.ctrl.mask_b : `TLP_FIX_MASK_B;
    last = r.step2 && (r.lines_left == 16'h0001);
    case (r.st)
      tlp_pkg::ST_IDLE: begin
        n.head.head_strobe_group = 6'h00;
        n.head.motor_phase       = `TLP_PH_OFF;
        if (start && r.ctrl.lines != 16'h0000 && r.ps2) begin
          n.err              = 1'b0;
          n.lines_left       = r.ctrl.lines;
          n.step2            = 1'b1;
          n.tmr              = 16'h0000;
          n.head.motor_phase = PHASE_TAB[{r.pidx, 2'b00} +: 4];
          shift_next         = 1'b1;
          n.sh_src2          = 1'b0;
          n.st               = tlp_pkg::ST_LATCH;
        end
      end
      tlp_pkg::ST_LATCH: begin
        // latch once strobes are off and shifting is done
        if (!r.sh_busy || r.tmr != 16'h0000) begin
          if (r.tmr < 16'(`TLP_LATCH_CYC + `TLP_SETUP_CYC)) begin
            n.tmr = r.tmr + 16'h0001;
          end
          n.head.head_latch = (r.tmr < 16'(`TLP_LATCH_CYC));
        end
        if (r.tmr >= 16'(`TLP_LATCH_CYC + `TLP_SETUP_CYC) && r.step_tmr == 20'h00000) begin
          n.st = tlp_pkg::ST_STEP;
        end
      end
      tlp_pkg::ST_STEP: begin
        n.pidx                   = r.pidx + 2'h1;
        n.head.motor_phase       = PHASE_TAB[{n.pidx, 2'b00} +: 4];
        n.step_tmr               = r.ctrl.period;
        n.step2                  = ~r.step2;
        n.tmr                    = 16'h0000;
        n.head.head_strobe_group = r.ctrl.one_div ? (ma | mb) : ma;
        n.st                     = tlp_pkg::ST_STRA;
        // next step's data shifts while this step prints
        if (!(n.step2 && r.lines_left == 16'h0001)) begin
          shift_next = 1'b1;
          n.sh_src2  = ~n.step2;
        end
      end
      tlp_pkg::ST_STRA: begin
        n.tmr = r.tmr + 16'h0001;
        if (r.tmr + 16'h0001 >= tstr) begin
          n.tmr = 16'h0000;
          if (r.ctrl.one_div) begin
            n.head.head_strobe_group = 6'h00;
            n.st                     = tlp_pkg::ST_PAUSE;
          end else begin
            n.head.head_strobe_group = mb;
            n.st                     = tlp_pkg::ST_STRB;
          end
        end
      end
      tlp_pkg::ST_STRB: begin
        n.tmr = r.tmr + 16'h0001;
        if (r.tmr + 16'h0001 >= tstr) begin
          n.head.head_strobe_group = 6'h00;
          step_done                = 1'b1;
        end
      end
      tlp_pkg::ST_PAUSE: begin
        n.tmr = r.tmr + 16'h0001;
        if (r.tmr >= 16'(PAUSE_CYC - 1)) begin
          step_done = 1'b1;
        end
      end
      default: n.st = tlp_pkg::ST_IDLE;
    endcase
    if (shift_next) begin
      n.sh_busy = 1'b1;
      n.sh_have = 1'b0;
      n.sh_idx  = 4'h0;
      n.sh_bit  = 5'h00;
      n.sh_div  = 3'h0;
    end
    // end of a step: count the line after its second step, then latch or stop
    if (step_done) begin
      n.tmr = 16'h0000;
      if (r.step2) begin
        n.lines_left = r.lines_left - 16'h0001;
      end
      n.st = last ? tlp_pkg::ST_IDLE : tlp_pkg::ST_LATCH;
      if (last) begin
        n.head.motor_phase = `TLP_PH_OFF;
      end
    end
    // paper out aborts the run at once
    if (!r.ps2 && r.st != tlp_pkg::ST_IDLE) begin
      n.st                     = tlp_pkg::ST_IDLE;
      n.err                    = 1'b1;
      n.sh_busy                = 1'b0;
      n.head                   = '0;
      n.head.motor_phase       = `TLP_PH_OFF;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r    <= '0;
      r.st <= tlp_pkg::ST_IDLE;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_idle_quiet: assert property (r.st == tlp_pkg::ST_IDLE |->
    r.head.head_strobe_group == 6'h00 && r.head.motor_phase == `TLP_PH_OFF)
    else $error("idle with motor or strobe active");
  a_paper_stop: assert property (!r.ps2 && r.st != tlp_pkg::ST_IDLE |=>
    r.st == tlp_pkg::ST_IDLE && r.head.head_strobe_group == 6'h00)
    else $error("no paper did not stop the run");
  a_latch_width: assert property ($rose(r.head.head_latch) |->
    r.head.head_latch[*5] ##1 !r.head.head_latch)
    else $error("latch pulse width wrong");
  a_latch_quiet: assert property (r.head.head_latch |->
    r.head.head_strobe_group == 6'h00 && !r.sh_busy)
    else $error("latch while strobing or shifting");
  a_group_order: assert property ($rose(r.st == tlp_pkg::ST_STRB) |->
    $past(r.st == tlp_pkg::ST_STRA) && r.head.head_strobe_group == mb)
    else $error("second group not after first");
  a_first_group: assert property (r.st == tlp_pkg::ST_STEP && !r.ctrl.one_div && r.ps2 |=>
    r.head.head_strobe_group == $past(ma) && r.head.motor_phase != $past(r.head.motor_phase))
    else $error("step did not move motor and fire first group");
  a_pause_len: assert property ($fell(r.st == tlp_pkg::ST_PAUSE) && r.ps2 |->
    $past(r.tmr) == 16'(PAUSE_CYC - 1))
    else $error("one division pause too short");
  a_step_wait: assert property (r.st == tlp_pkg::ST_LATCH && n.st == tlp_pkg::ST_STEP |->
    r.step_tmr == 20'h00000 && !r.sh_busy)
    else $error("motor stepped before period or transfer ended");
  a_xfer_data: assert property ($rose(r.head.xfer_clk) |->
    $stable(r.head.serial_dot_input))
    else $error("dot data changed at transfer clock rise");
  a_resend_src: assert property (r.st == tlp_pkg::ST_STEP && r.step2 && r.ps2 |=>
    r.sh_src2 && r.sh_busy)
    else $error("second step data not taken from line buffer");
  a_short_str: assert property (r.step2 && r.ctrl.t1 != 16'h0000 |->
    tstr < r.ctrl.t1)
    else $error("second step strobe not shorter");

  c_run_start: cover property (r.st == tlp_pkg::ST_IDLE ##1 r.st == tlp_pkg::ST_LATCH);
  c_two_div:   cover property (r.st == tlp_pkg::ST_STRB ##1 r.st == tlp_pkg::ST_LATCH);
  c_one_div:   cover property ($fell(r.st == tlp_pkg::ST_PAUSE));
  c_paper_out: cover property (!r.ps2 && r.st == tlp_pkg::ST_STRA);
endmodule
`default_nettype wire

// file: sim/tlp_head_model.sv
// behavioural model of the print mechanism: head shift register, dot storage, paper sensor
`timescale 1ns/100ps
`default_nettype none

module tlp_head_model (
  input  wire logic       xfer_clk,
  input  wire logic       din,
  input  wire logic       latch,
  input  wire logic [5:0] strobe,
  input  wire logic       paper,
  output logic            paper_sense_out,
  output logic            over_limit
);
  logic [383:0] sr;
  logic [383:0] store;
  int           n;

  // sensor output follows the paper, low with none present
  assign paper_sense_out = paper;
  // power-up contents of the head
  initial begin
    sr = '0;
    store = '0;
    over_limit = 1'b0;
  end
  // serial dots enter on the transfer clock rise
  always @(posedge xfer_clk) sr <= {sr[382:0], din};
  // latch pulse copies the shift register into dot storage
  always @(negedge latch) store <= sr;
  // heated dots summed over the active groups, sticky flag on overload
  always @(strobe or store) begin
    n = 0;
    for (int g = 0; g < 6; g++) begin
      if (strobe[g]) n += $countones(store[64 * g +: 64]);
    end
    if (n > 64) over_limit = 1'b1;
  end
endmodule
`default_nettype wire

// file: sim/tlp_seq_tb.sv
// self-checking bench of the line print sequencer
`timescale 1ns/100ps
`default_nettype none
`include "tlp_defines.svh"

module tlp_seq_tb;
  localparam int PAUSE = 20;
  logic               pclk;
  logic               presetn;
  logic [7:0]         paddr;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               paper;
  logic               sense;
  logic               over;
  tlp_pkg::tlp_head_s hp;
  logic [31:0]        rd;
  logic               er;
  logic [383:0]       line;
  logic [5:0]         s_prev;
  logic [3:0]         ph_prev;
  logic [3:0]         last_ph;
  logic [5:0]         strq[$];
  logic [383:0]       stq[$];
  logic [3:0]         phq[$];
  int                 lenq[$];
  int                 gapq[$];
  int                 len;
  int                 ovl;
  int                 cyc;
  bit                 after_str;
  int                 n_mismatch;
  int                 cmp_count;

  tlp_seq #(.PAUSE_CYC(PAUSE)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .paper_sense_out(sense), .head_pins(hp));
  tlp_head_model hm (.xfer_clk(hp.xfer_clk), .din(hp.serial_dot_input),
    .latch(hp.head_latch), .strobe(hp.head_strobe_group), .paper(paper),
    .paper_sense_out(sense), .over_limit(over));

  // free-running clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // dot word i of the test line, three dots each
  function automatic logic [31:0] wd(input int i);
    return 32'h8000_0001 | (32'h0000_0010 << i);
  endfunction

  // next entry of the excitation table
  function automatic logic [3:0] nx(input logic [3:0] p);
    case (p)
      4'hA: return 4'h6;
      4'h6: return 4'h5;
      4'h5: return 4'h9;
      default: return 4'hA;
    endcase
  endfunction

  // compare and count
  task automatic chk(input string nm, input logic [383:0] got, input logic [383:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // one apb transfer, waits for pready with no fixed latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // push dot words a..b into the data fifo
  task automatic fill(input int a, input int b);
    for (int i = a; i <= b; i++) apb(1'b1, `TLP_A_DATA, wd(i));
  endtask

  // one-line run: fifo filled to refusal, started, drained until idle
  task automatic run(input logic [31:0] ctrl, input logic [15:0] s1, input logic [15:0] s2);
    strq.delete();
    stq.delete();
    phq.delete();
    lenq.delete();
    gapq.delete();
    after_str = 1'b0;
    ovl = 0;
    apb(1'b1, `TLP_A_STRB1, {16'h0000, s1});
    apb(1'b1, `TLP_A_STRB2, {16'h0000, s2});
    apb(1'b1, `TLP_A_PERIOD, 32'h0000_0064);
    apb(1'b1, `TLP_A_LINES, 32'h0000_0001);
    fill(0, 7);
    apb(1'b0, `TLP_A_STATUS, 32'h0);
    chk("fifo_full", rd[7:4], 4'h8);
    apb(1'b1, `TLP_A_CTRL, ctrl);
    fill(8, 11);
    do apb(1'b0, `TLP_A_STATUS, 32'h0); while (rd[0] !== 1'b0);
    chk("fifo_empty", rd[7:4], 4'h0);
    chk("idle_pins", hp, 15'h0000);
  endtask

  // register reset values, unmapped access, refused start without paper
  task automatic t_regs;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset_value", rd, 32'h0);
    end
    apb(1'b1, `TLP_A_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, `TLP_A_STATUS, 32'h0);
    chk("status_idle", rd, 32'h0000_0002);
    apb(1'b1, 8'h1C, 32'h1234_5678);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", {er, rd}, {1'b1, 32'h0});
    apb(1'b1, `TLP_A_PERIOD, 32'h000F_FFFF);
    apb(1'b0, `TLP_A_PERIOD, 32'h0);
    chk("period_rw", rd, 32'h000F_FFFF);
    chk("idle_pins", hp, 15'h0000);
    paper <= 1'b0;
    apb(1'b1, `TLP_A_LINES, 32'h0000_0001);
    apb(1'b1, `TLP_A_CTRL, 32'h0000_0001);
    apb(1'b0, `TLP_A_STATUS, 32'h0);
    chk("no_paper_start", rd[2:0], 3'h0);
    paper <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  // fixed two-division run
  task automatic t_fixed;
    run(32'h0000_0001, 16'h000A, 16'h0006);
    chk("n_strobe", strq.size(), 4);
    for (int i = 0; i < 4; i++) begin
      chk("strobe_set", strq[i], i[0] ? 6'h38 : 6'h07);
      chk("strobe_len", lenq[i], i < 2 ? 10 : 6);
      chk("dot_store", stq[i], line);
    end
    chk("n_phase", phq.size(), 3);
    for (int i = 0; i < 2; i++) chk("phase_adv", phq[i + 1], nx(phq[i]));
    chk("overlap", ovl > 0, 1'b1);
    last_ph = phq[$];
  endtask

  // dynamic groups, second strobe clamped below the first
  task automatic t_dyn;
    run(32'h003A_0505, 16'h000A, 16'h000A);
    chk("redrive", phq[0], last_ph);
    for (int i = 0; i < 4; i++) begin
      chk("dyn_set", strq[i], i[0] ? 6'h3A : 6'h05);
      chk("dyn_len", lenq[i], i < 2 ? 10 : 9);
    end
  endtask

  // one division: long strobes so the gap is pause plus latch and setup
  task automatic t_one;
    run(32'h0000_0003, 16'h0FA0, 16'h0DAC);
    chk("one_set", {strq.size(), strq[0], strq[1]}, {32'h2, 6'h3F, 6'h3F});
    chk("one_len", {lenq[0], lenq[1]}, {32'h0FA0, 32'h0DAC});
    chk("pause", gapq[0] >= PAUSE + 20, 1'b1);
    chk("dot_limit", over, 1'b0);
  endtask

  // paper lost while strobing
  task automatic t_paper;
    fill(0, 7);
    apb(1'b1, `TLP_A_CTRL, 32'h0000_0001);
    fill(8, 11);
    while (hp.head_strobe_group === 6'h00) @(posedge pclk);
    paper <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("abort_pins", hp, 15'h0000);
    apb(1'b0, `TLP_A_STATUS, 32'h0);
    chk("abort_status", rd[2:0], 3'h4);
    paper <= 1'b1;
  endtask

  // watches head pins: strobe sets, lengths, gaps, phases, latch placement
  always @(posedge pclk) begin
    if (hp.head_latch === 1'b1) chk("latch_strobe", hp.head_strobe_group, 6'h00);
    if (hp.head_strobe_group !== 6'h00 && hp.xfer_clk === 1'b1) ovl++;
    if (hp.motor_phase !== ph_prev && hp.motor_phase !== 4'h0) phq.push_back(hp.motor_phase);
    ph_prev = hp.motor_phase;
    if (hp.head_strobe_group !== s_prev) begin
      if (s_prev !== 6'h00) begin
        lenq.push_back(len);
        after_str = 1'b1;
      end else if (after_str) gapq.push_back(len);
      if (hp.head_strobe_group !== 6'h00) begin
        strq.push_back(hp.head_strobe_group);
        stq.push_back(hm.store);
      end
      len = 1;
    end else len++;
    s_prev = hp.head_strobe_group;
  end

  // cuts a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      final_report();
    end
  end

  // counts and verdict
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    paper = 1'b1;
    s_prev = 6'h00;
    ph_prev = 4'h0;
    line = '0;
    for (int i = 0; i < 12; i++) line = {line[351:0], wd(i)};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_regs();
    t_fixed();
    t_dyn();
    t_one();
    t_paper();
    final_report();
  end
endmodule
`default_nettype wire
